//--- tcs_top.sv
// Timer subsystem: 16-bit timer, 40-bit radio timer, two 8-bit timers.
// Assumes an AXI4-Lite master on aclk and radio event pulses on aclk.
//
// Overview of operation
// - 16-bit timer: prescaler and programmable period
// - Five channels, each with 16-bit compare
// - Channel drives PWM or captures on edge
// - IR mode: count 8-bit periods, AND outputs
// - Radio timer: 16-bit counter plus 24-bit overflow
// - Capture 40-bit time on frame events
// - Two compares and overflow compares start radio
// - 8-bit timers: own prescaler and period
// - One 8-bit compare channel per 8-bit timer
// - 8-bit channel generates PWM output
// - Timer overflows trigger DMA transfers
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module tcs_top
(
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [tcs_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	output logic [1:0]                        s_axi_bresp,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	input  wire logic [tcs_pkg::ADDR_W-1:0]   s_axi_araddr,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	input  wire logic [tcs_pkg::NCH-1:0]      ta_cap_in,
	input  wire tcs_pkg::tcs_radio_evt_t      radio_evt,
	output logic [tcs_pkg::NCH-1:0]           ta_out,
	output logic [1:0]                        t8_out,
	output logic                              radio_rx_start,
	output logic                              radio_tx_start,
	output logic [3:0]                        dma_trig,
	output logic                              irq
);
	import tcs_pkg::*;

	// Register block
	logic [CTRL_W-1:0] ctrl_ff,      nxt_ctrl;
	logic [7:0]        ta_presc_ff,  nxt_ta_presc;
	logic [15:0]       ta_period_ff, nxt_ta_period;
	logic [15:0]       cc_ff [NCH],  nxt_cc [NCH];
	logic [15:0]       rt_period_ff, nxt_rt_period;
	logic [15:0]       rt_cmp_ff [2], nxt_rt_cmp [2];
	logic [23:0]       rt_ocmp_ff [2], nxt_rt_ocmp [2];
	tcs_t8_cfg_t       t8a_cfg_ff,   nxt_t8a_cfg;
	tcs_t8_cfg_t       t8b_cfg_ff,   nxt_t8b_cfg;
	logic [ST_W-1:0]   status_ff,    nxt_status;
	logic [ST_W-1:0]   mask_ff,      nxt_mask;
	logic              irq_ff,       nxt_irq;
	// Bus handshake
	logic              awhave_ff,    nxt_awhave;
	logic [7:0]        awaddr_ff,    nxt_awaddr;
	logic              whave_ff,     nxt_whave;
	logic [31:0]       wdata_ff,     nxt_wdata;
	logic [3:0]        wstrb_ff,     nxt_wstrb;
	logic              awready_ff,   nxt_awready;
	logic              wready_ff,    nxt_wready;
	logic              bvalid_ff,    nxt_bvalid;
	logic [1:0]        bresp_ff,     nxt_bresp;
	logic              arready_ff,   nxt_arready;
	logic              rvalid_ff,    nxt_rvalid;
	logic [31:0]       rdata_ff,     nxt_rdata;
	logic [1:0]        rresp_ff,     nxt_rresp;
	// Timers
	logic [7:0]        ta_pre_ff,    nxt_ta_pre;
	logic [15:0]       ta_cnt_ff,    nxt_ta_cnt;
	logic [NCH-1:0]    ta_out_ff,    nxt_ta_out;
	logic [15:0]       rt_cnt_ff,    nxt_rt_cnt;
	logic [23:0]       rt_ovf_ff,    nxt_rt_ovf;
	logic [39:0]       rt_cap_ff,    nxt_rt_cap;
	logic              rx_ff,        nxt_rx;
	logic              tx_ff,        nxt_tx;
	logic [3:0]        dma_ff,       nxt_dma;
	logic [NCH-1:0]    cap_s1_ff,    cap_s2_ff,    cap_s3_ff;
	logic [NCH-1:0]    cap_edge;
	logic [ST_W-1:0]   ev;
	logic              t8a_ovf,      t8a_match,    t8a_pwm;
	logic              t8b_ovf,      t8b_match,    t8b_pwm;
	logic [7:0]        t8a_cnt,      t8b_cnt;

	////////////////////////////////////////////////////////////////////////////
	// The two 8-bit timers
	tcs_t8 u_t8a
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.en      (ctrl_ff[CTRL_T8A_EN]),
		.cfg     (t8a_cfg_ff),
		.ovf     (t8a_ovf),
		.match   (t8a_match),
		.pwm     (t8a_pwm),
		.count   (t8a_cnt)
	);

	tcs_t8 u_t8b
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.en      (ctrl_ff[CTRL_T8B_EN]),
		.cfg     (t8b_cfg_ff),
		.ovf     (t8b_ovf),
		.match   (t8b_match),
		.pwm     (t8b_pwm),
		.count   (t8b_cnt)
	);

	////////////////////////////////////////////////////////////////////////////
	// Capture pin synchroniser, edge taken from the second and third stage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cap_s1_ff <= '0;
			cap_s2_ff <= '0;
			cap_s3_ff <= '0;
		end
		else
		begin
			cap_s1_ff <= ta_cap_in;
			cap_s2_ff <= cap_s1_ff;
			cap_s3_ff <= cap_s2_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer next state and events
	always_comb
	begin
		logic ta_tick;
		logic [15:0] rt_next;
		ta_tick     = 1'b0;
		rt_next     = '0;
		nxt_ta_pre  = ta_pre_ff;
		nxt_ta_cnt  = ta_cnt_ff;
		nxt_rt_cnt  = rt_cnt_ff;
		nxt_rt_ovf  = rt_ovf_ff;
		nxt_rt_cap  = rt_cap_ff;
		nxt_rx      = 1'b0;
		nxt_tx      = 1'b0;
		ev          = '0;
		// 16-bit timer: prescaled or IR-driven tick
		cap_edge = cap_s2_ff & ~cap_s3_ff & ctrl_ff[CTRL_CAP_LSB +: NCH]
			& {NCH{ctrl_ff[CTRL_TA_EN]}};
		if (ctrl_ff[CTRL_TA_EN])
		begin
			if (ctrl_ff[CTRL_TA_IR])
			begin
				nxt_ta_pre = '0;
				ta_tick    = t8a_ovf;
			end
			else if (tcs_presc_wrap(ta_pre_ff, ta_presc_ff))
			begin
				nxt_ta_pre = '0;
				ta_tick    = 1'b1;
			end
			else
				nxt_ta_pre = ta_pre_ff + 8'h01;
		end
		else
		begin
			nxt_ta_pre = '0;
			nxt_ta_cnt = '0;
		end
		if (ta_tick)
		begin
			for (int i = 0; i < NCH; i++)
				ev[ST_TA_CH+i] = (ta_cnt_ff == cc_ff[i])
					&& !ctrl_ff[CTRL_CAP_LSB+i];
			if (ta_cnt_ff >= ta_period_ff)
			begin
				nxt_ta_cnt       = '0;
				ev[ST_TA_OVF]    = 1'b1;
			end
			else
				nxt_ta_cnt = ta_cnt_ff + 16'h0001;
		end
		ev[ST_TA_CH +: NCH] = ev[ST_TA_CH +: NCH] | cap_edge;
		// PWM outputs, gated by the 8-bit carrier in IR mode
		for (int i = 0; i < NCH; i++)
			nxt_ta_out[i] = ctrl_ff[CTRL_TA_EN] && !ctrl_ff[CTRL_CAP_LSB+i]
				&& (nxt_ta_cnt < cc_ff[i])
				&& (!ctrl_ff[CTRL_TA_IR] || t8a_pwm);
		// Radio timer: counter with 24-bit period counter above it
		if (ctrl_ff[CTRL_RT_EN])
		begin
			for (int i = 0; i < 2; i++)
			begin
				ev[ST_RT_CMP+i]  = (rt_cnt_ff == rt_cmp_ff[i]);
				ev[ST_RT_OCMP+i] = (rt_ovf_ff == rt_ocmp_ff[i])
					&& (rt_cnt_ff >= rt_period_ff);
			end
			nxt_rx = ctrl_ff[CTRL_RX_EN] && ev[ST_RT_CMP]
				&& (rt_ovf_ff == rt_ocmp_ff[0]);
			nxt_tx = ctrl_ff[CTRL_TX_EN] && ev[ST_RT_CMP+1]
				&& (rt_ovf_ff == rt_ocmp_ff[1]);
			rt_next = rt_cnt_ff + 16'h0001;
			if (rt_cnt_ff >= rt_period_ff)
			begin
				nxt_rt_cnt     = '0;
				nxt_rt_ovf     = rt_ovf_ff + 24'h000001;
				ev[ST_RT_OVF]  = 1'b1;
			end
			else
				nxt_rt_cnt = rt_next;
		end
		else
		begin
			rt_next    = '0;
			nxt_rt_cnt = '0;
			nxt_rt_ovf = '0;
		end
		if (radio_evt.sfd || radio_evt.tx_end)
		begin
			nxt_rt_cap    = {rt_ovf_ff, rt_cnt_ff};
			ev[ST_RT_CAP] = 1'b1;
		end
		ev[ST_T8A_OVF] = t8a_ovf;
		ev[ST_T8A_CH]  = t8a_match;
		ev[ST_T8B_OVF] = t8b_ovf;
		ev[ST_T8B_CH]  = t8b_match;
		nxt_dma = {t8b_ovf, t8a_ovf, ev[ST_RT_OVF], ev[ST_TA_OVF]};
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave, register writes, read mux, status and interrupt
	always_comb
	begin
		logic       do_wr;
		logic       do_rd;
		logic [7:0] ra;
		logic [31:0] wv;
		do_wr         = awhave_ff && whave_ff && !bvalid_ff;
		do_rd         = s_axi_arvalid && arready_ff;
		ra            = s_axi_araddr;
		wv            = '0;
		nxt_awhave    = awhave_ff || (s_axi_awvalid && awready_ff);
		nxt_awaddr    = (s_axi_awvalid && awready_ff) ? s_axi_awaddr : awaddr_ff;
		nxt_whave     = whave_ff || (s_axi_wvalid && wready_ff);
		nxt_wdata     = (s_axi_wvalid && wready_ff) ? s_axi_wdata : wdata_ff;
		nxt_wstrb     = (s_axi_wvalid && wready_ff) ? s_axi_wstrb : wstrb_ff;
		nxt_bvalid    = bvalid_ff && !s_axi_bready;
		nxt_bresp     = bresp_ff;
		nxt_rvalid    = rvalid_ff && !s_axi_rready;
		nxt_rdata     = rdata_ff;
		nxt_rresp     = rresp_ff;
		nxt_ctrl      = ctrl_ff;
		nxt_ta_presc  = ta_presc_ff;
		nxt_ta_period = ta_period_ff;
		nxt_cc        = cc_ff;
		nxt_rt_period = rt_period_ff;
		nxt_rt_cmp    = rt_cmp_ff;
		nxt_rt_ocmp   = rt_ocmp_ff;
		nxt_t8a_cfg   = t8a_cfg_ff;
		nxt_t8b_cfg   = t8b_cfg_ff;
		nxt_mask      = mask_ff;
		nxt_status    = status_ff;
		// Write once both address and data are held
		if (do_wr)
		begin
			nxt_awhave = 1'b0;
			nxt_whave  = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = RESP_OKAY;
			unique case (awaddr_ff)
				A_CTRL:      nxt_ctrl = CTRL_W'(tcs_wmerge(32'(ctrl_ff), wdata_ff, wstrb_ff));
				A_TA_PRESC:  nxt_ta_presc = 8'(tcs_wmerge(32'(ta_presc_ff), wdata_ff, wstrb_ff));
				A_TA_PERIOD: nxt_ta_period = 16'(tcs_wmerge(32'(ta_period_ff), wdata_ff,
					wstrb_ff));
				A_RT_PERIOD: nxt_rt_period = 16'(tcs_wmerge(32'(rt_period_ff), wdata_ff,
					wstrb_ff));
				A_T8A_CFG:   nxt_t8a_cfg = 24'(tcs_wmerge(32'(t8a_cfg_ff), wdata_ff, wstrb_ff));
				A_T8B_CFG:   nxt_t8b_cfg = 24'(tcs_wmerge(32'(t8b_cfg_ff), wdata_ff, wstrb_ff));
				A_MASK:      nxt_mask = ST_W'(tcs_wmerge(32'(mask_ff), wdata_ff, wstrb_ff));
				default:
				begin
					nxt_bresp = RESP_SLV;
					for (int i = 0; i < NCH; i++)
						if (awaddr_ff == A_TA_CC0 + 8'(i) * WORD_STEP)
						begin
							nxt_cc[i]  = 16'(tcs_wmerge(32'(cc_ff[i]), wdata_ff, wstrb_ff));
							nxt_bresp  = RESP_OKAY;
						end
					for (int i = 0; i < 2; i++)
					begin
						if (awaddr_ff == A_RT_CMP0 + 8'(i) * WORD_STEP)
						begin
							nxt_rt_cmp[i] = 16'(tcs_wmerge(32'(rt_cmp_ff[i]), wdata_ff,
								wstrb_ff));
							nxt_bresp     = RESP_OKAY;
						end
						if (awaddr_ff == A_RT_OCMP0 + 8'(i) * WORD_STEP)
						begin
							nxt_rt_ocmp[i] = 24'(tcs_wmerge(32'(rt_ocmp_ff[i]), wdata_ff,
								wstrb_ff));
							nxt_bresp      = RESP_OKAY;
						end
					end
				end
			endcase
		end
		// Capture overrides a software write in the same cycle
		for (int i = 0; i < NCH; i++)
			if (cap_edge[i])
				nxt_cc[i] = ta_cnt_ff;
		// Read data registered, unmapped gives error and zero
		if (do_rd)
		begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = RESP_OKAY;
			unique case (ra)
				A_CTRL:      nxt_rdata = 32'(ctrl_ff);
				A_TA_PRESC:  nxt_rdata = 32'(ta_presc_ff);
				A_TA_PERIOD: nxt_rdata = 32'(ta_period_ff);
				A_TA_COUNT:  nxt_rdata = 32'(ta_cnt_ff);
				A_RT_PERIOD: nxt_rdata = 32'(rt_period_ff);
				A_RT_COUNT:  nxt_rdata = 32'(rt_cnt_ff);
				A_RT_OVF:    nxt_rdata = 32'(rt_ovf_ff);
				A_RT_CAPLO:  nxt_rdata = 32'(rt_cap_ff[15:0]);
				A_RT_CAPHI:  nxt_rdata = 32'(rt_cap_ff[39:16]);
				A_T8A_CFG:   nxt_rdata = 32'(t8a_cfg_ff);
				A_T8B_CFG:   nxt_rdata = 32'(t8b_cfg_ff);
				A_T8_COUNT:  nxt_rdata = 32'({t8b_cnt, t8a_cnt});
				A_STATUS:    nxt_rdata = 32'(status_ff);
				A_MASK:      nxt_rdata = 32'(mask_ff);
				default:
				begin
					wv        = '0;
					nxt_rresp = RESP_SLV;
					for (int i = 0; i < NCH; i++)
						if (ra == A_TA_CC0 + 8'(i) * WORD_STEP)
						begin
							wv        = 32'(cc_ff[i]);
							nxt_rresp = RESP_OKAY;
						end
					for (int i = 0; i < 2; i++)
					begin
						if (ra == A_RT_CMP0 + 8'(i) * WORD_STEP)
						begin
							wv        = 32'(rt_cmp_ff[i]);
							nxt_rresp = RESP_OKAY;
						end
						if (ra == A_RT_OCMP0 + 8'(i) * WORD_STEP)
						begin
							wv        = 32'(rt_ocmp_ff[i]);
							nxt_rresp = RESP_OKAY;
						end
					end
					nxt_rdata = wv;
				end
			endcase
			if (ra == A_STATUS)
				nxt_status = '0;
		end
		// Sticky flags; a new event beats the read clear
		nxt_status  = nxt_status | ev;
		nxt_irq     = |(nxt_status & mask_ff);
		nxt_awready = !nxt_awhave && !nxt_bvalid;
		nxt_wready  = !nxt_whave && !nxt_bvalid;
		nxt_arready = !nxt_rvalid;
	end

	////////////////////////////////////////////////////////////////////////////
	// All state registers except the capture synchroniser
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff <= '0;        ta_presc_ff <= '0;      ta_period_ff <= RST_P16;
			cc_ff <= '{default: '0};                      rt_period_ff <= RST_P16;
			rt_cmp_ff <= '{default: '0};                  rt_ocmp_ff <= '{default: '0};
			t8a_cfg_ff <= RST_T8; t8b_cfg_ff <= RST_T8;
			status_ff <= '0;      mask_ff <= '0;          irq_ff <= 1'b0;
			awhave_ff <= 1'b0;    awaddr_ff <= '0;        whave_ff <= 1'b0;
			wdata_ff <= '0;       wstrb_ff <= '0;         awready_ff <= 1'b0;
			wready_ff <= 1'b0;    bvalid_ff <= 1'b0;      bresp_ff <= RESP_OKAY;
			arready_ff <= 1'b0;   rvalid_ff <= 1'b0;      rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
			ta_pre_ff <= '0;      ta_cnt_ff <= '0;        ta_out_ff <= '0;
			rt_cnt_ff <= '0;      rt_ovf_ff <= '0;        rt_cap_ff <= '0;
			rx_ff <= 1'b0;        tx_ff <= 1'b0;          dma_ff <= '0;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;  ta_presc_ff <= nxt_ta_presc; ta_period_ff <= nxt_ta_period;
			cc_ff <= nxt_cc;      rt_period_ff <= nxt_rt_period;
			rt_cmp_ff <= nxt_rt_cmp;                      rt_ocmp_ff <= nxt_rt_ocmp;
			t8a_cfg_ff <= nxt_t8a_cfg;                    t8b_cfg_ff <= nxt_t8b_cfg;
			status_ff <= nxt_status; mask_ff <= nxt_mask; irq_ff <= nxt_irq;
			awhave_ff <= nxt_awhave; awaddr_ff <= nxt_awaddr; whave_ff <= nxt_whave;
			wdata_ff <= nxt_wdata; wstrb_ff <= nxt_wstrb; awready_ff <= nxt_awready;
			wready_ff <= nxt_wready; bvalid_ff <= nxt_bvalid; bresp_ff <= nxt_bresp;
			arready_ff <= nxt_arready; rvalid_ff <= nxt_rvalid; rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			ta_pre_ff <= nxt_ta_pre; ta_cnt_ff <= nxt_ta_cnt; ta_out_ff <= nxt_ta_out;
			rt_cnt_ff <= nxt_rt_cnt; rt_ovf_ff <= nxt_rt_ovf; rt_cap_ff <= nxt_rt_cap;
			rx_ff <= nxt_rx;      tx_ff <= nxt_tx;        dma_ff <= nxt_dma;
		end
	end

	// Outputs straight from flip-flops
	assign s_axi_awready  = awready_ff;
	assign s_axi_wready   = wready_ff;
	assign s_axi_bvalid   = bvalid_ff;
	assign s_axi_bresp    = bresp_ff;
	assign s_axi_arready  = arready_ff;
	assign s_axi_rvalid   = rvalid_ff;
	assign s_axi_rdata    = rdata_ff;
	assign s_axi_rresp    = rresp_ff;
	assign ta_out         = ta_out_ff;
	assign t8_out         = {t8b_pwm, t8a_pwm};
	assign radio_rx_start = rx_ff;
	assign radio_tx_start = tx_ff;
	assign dma_trig       = dma_ff;
	assign irq            = irq_ff;

endmodule : tcs_top

//--- tcs_pkg.sv
// Constants, types and helpers shared by the timer subsystem files.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package tcs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Bus geometry and responses
	localparam int          ADDR_W    = 8;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLV  = 2'h2;

	// Register byte offsets
	localparam logic [7:0]  A_CTRL      = 8'h00;
	localparam logic [7:0]  A_TA_PRESC  = 8'h04;
	localparam logic [7:0]  A_TA_PERIOD = 8'h08;
	localparam logic [7:0]  A_TA_COUNT  = 8'h0C;
	localparam logic [7:0]  A_TA_CC0    = 8'h10;
	localparam logic [7:0]  A_RT_PERIOD = 8'h24;
	localparam logic [7:0]  A_RT_COUNT  = 8'h28;
	localparam logic [7:0]  A_RT_OVF    = 8'h2C;
	localparam logic [7:0]  A_RT_CAPLO  = 8'h30;
	localparam logic [7:0]  A_RT_CAPHI  = 8'h34;
	localparam logic [7:0]  A_RT_CMP0   = 8'h38;
	localparam logic [7:0]  A_RT_OCMP0  = 8'h40;
	localparam logic [7:0]  A_T8A_CFG   = 8'h48;
	localparam logic [7:0]  A_T8B_CFG   = 8'h4C;
	localparam logic [7:0]  A_T8_COUNT  = 8'h50;
	localparam logic [7:0]  A_STATUS    = 8'h54;
	localparam logic [7:0]  A_MASK      = 8'h58;
	localparam logic [7:0]  WORD_STEP   = 8'h04;

	// Control register fields
	localparam int          NCH          = 5;
	localparam int          CTRL_W       = 12;
	localparam int          CTRL_TA_EN   = 0;
	localparam int          CTRL_TA_IR   = 1;
	localparam int          CTRL_RT_EN   = 2;
	localparam int          CTRL_T8A_EN  = 3;
	localparam int          CTRL_T8B_EN  = 4;
	localparam int          CTRL_CAP_LSB = 5;
	localparam int          CTRL_RX_EN   = 10;
	localparam int          CTRL_TX_EN   = 11;

	// Status and mask fields
	localparam int          ST_W       = 16;
	localparam int          ST_TA_OVF  = 0;
	localparam int          ST_TA_CH   = 1;
	localparam int          ST_RT_OVF  = 6;
	localparam int          ST_RT_CAP  = 7;
	localparam int          ST_RT_CMP  = 8;
	localparam int          ST_RT_OCMP = 10;
	localparam int          ST_T8A_OVF = 12;
	localparam int          ST_T8A_CH  = 13;
	localparam int          ST_T8B_OVF = 14;
	localparam int          ST_T8B_CH  = 15;

	// Reset values
	localparam logic [15:0] RST_P16 = 16'hFFFF;
	localparam logic [23:0] RST_T8  = 24'h00FF00;

	////////////////////////////////////////////////////////////////////////////
	// 8-bit timer setup: compare, period, prescale divisor
	typedef struct packed {
		logic [7:0] cmp;
		logic [7:0] period;
		logic [7:0] presc;
	} tcs_t8_cfg_t;

	// Frame events from the radio core, one-cycle pulses
	typedef struct packed {
		logic sfd;
		logic tx_end;
	} tcs_radio_evt_t;

	// Prescaler reaches its divisor
	function automatic logic tcs_presc_wrap(logic [7:0] cnt, logic [7:0] div);
		return cnt >= div;
	endfunction : tcs_presc_wrap

	// Byte-lane merge of a write into a register word
	function automatic logic [31:0] tcs_wmerge(logic [31:0] old, logic [31:0] data,
		logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		return res;
	endfunction : tcs_wmerge

endpackage : tcs_pkg

//--- tcs_t8.sv
// One 8-bit timer with prescaler, period and one PWM channel.
// Assumes configuration held stable by the register block.
`timescale 1ns/1ps
module tcs_t8
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 en,
	input  wire tcs_pkg::tcs_t8_cfg_t cfg,
	output logic                      ovf,
	output logic                      match,
	output logic                      pwm,
	output logic [7:0]                count
);
	import tcs_pkg::*;

	logic [7:0] pre_ff;
	logic [7:0] nxt_pre;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic       ovf_ff;
	logic       nxt_ovf;
	logic       match_ff;
	logic       nxt_match;
	logic       pwm_ff;
	logic       nxt_pwm;

	////////////////////////////////////////////////////////////////////////////
	// Prescaled counting, wrap at period, PWM below compare
	always_comb
	begin
		nxt_pre   = pre_ff;
		nxt_cnt   = cnt_ff;
		nxt_ovf   = 1'b0;
		nxt_match = 1'b0;
		if (en)
		begin
			if (tcs_presc_wrap(pre_ff, cfg.presc))
			begin
				nxt_pre   = '0;
				nxt_match = (cnt_ff == cfg.cmp);
				if (cnt_ff >= cfg.period)
				begin
					nxt_cnt = '0;
					nxt_ovf = 1'b1;
				end
				else
					nxt_cnt = cnt_ff + 8'h01;
			end
			else
				nxt_pre = pre_ff + 8'h01;
		end
		else
		begin
			nxt_pre = '0;
			nxt_cnt = '0;
		end
		nxt_pwm = en && (nxt_cnt < cfg.cmp);
	end

	// State registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_ff   <= '0;
			cnt_ff   <= '0;
			ovf_ff   <= 1'b0;
			match_ff <= 1'b0;
			pwm_ff   <= 1'b0;
		end
		else
		begin
			pre_ff   <= nxt_pre;
			cnt_ff   <= nxt_cnt;
			ovf_ff   <= nxt_ovf;
			match_ff <= nxt_match;
			pwm_ff   <= nxt_pwm;
		end
	end

	assign ovf   = ovf_ff;
	assign match = match_ff;
	assign pwm   = pwm_ff;
	assign count = cnt_ff;

endmodule : tcs_t8

//--- tcs_radio_model.sv
// Radio core stand-in: frame event pulses on request.
// Assumes single-cycle request strobes from the bench on aclk.
`timescale 1ns/1ps
module tcs_radio_model
(
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               fire_sfd,
	input  wire logic               fire_end,
	output tcs_pkg::tcs_radio_evt_t radio_evt
);
	import tcs_pkg::*;
	tcs_radio_evt_t evt_ff;
	// One-cycle frame pulses, quiet in reset
	always_ff @(posedge aclk)
	begin
		evt_ff <= aresetn ? tcs_radio_evt_t'{sfd: fire_sfd, tx_end: fire_end} : '0;
	end
	assign radio_evt = evt_ff;
endmodule : tcs_radio_model

//--- tcs_top_props.sv
// Bus handshake and radio rx start checks on the timer ports.
// Assumes one aclk domain, aresetn synchronous active low.
`timescale 1ns/1ps
module tcs_top_props
(
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       radio_rx_start
);
	import tcs_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Both write channels taken at one edge
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rtake;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_write_resp: assert property (s_wtake |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_read_resp: assert property (s_rtake |=> s_axi_rvalid)
		else $error("read response late");
	chk_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	chk_rresp_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response not released");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_bad_addr: assert property (s_rtake and s_axi_araddr == 8'hFC |=>
		s_axi_rresp == RESP_SLV && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_rx_pulse: assert property (radio_rx_start |=> !radio_rx_start)
		else $error("rx start longer than one cycle");
endmodule : tcs_top_props
bind tcs_top tcs_top_props i_tcs_top_props (.*);

//--- tb_top.sv
// Self-checking bench for the timer subsystem over AXI4-Lite.
// Assumes the register map and bus timing of tcs_pkg.
`timescale 1ns/1ps
module tb_top;
	import tcs_pkg::*;
	logic aclk, aresetn, fire_sfd, fire_end, irq, radio_rx_start, radio_tx_start;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]     s_axi_awaddr, s_axi_araddr;
	logic [31:0]    s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]     s_axi_wstrb, dma_trig;
	logic [1:0]     s_axi_bresp, s_axi_rresp, t8_out, rr;
	logic [4:0]     ta_cap_in, ta_out;
	logic [6:0]     ev;
	tcs_radio_evt_t radio_evt;
	int             num_errors, tests_run, cyc, c[7];
	tcs_top i_tcs_top (.*);
	tcs_radio_model i_tcs_radio_model (.*);
	assign ev = {radio_tx_start, radio_rx_start, dma_trig[2:0], t8_out[0], ta_out[0]};
	always #2 aclk = ~aclk;
	// Hang guard
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize;
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ap;
		logic wp;
		ap = 1;
		wp = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (ap || wp)
		begin
			@(posedge aclk);
			ap = ap && !s_axi_awready;
			wp = wp && !s_axi_wready;
			s_axi_awvalid <= ap;
			s_axi_wvalid <= wp;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rr = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask : rd
	task automatic sample(input int n);
		c = '{default: 0};
		repeat (n)
		begin
			@(posedge aclk);
			for (int i = 0; i < 7; i++)
				c[i] += ev[i];
		end
	endtask : sample
	////////////////////////////////////////
	task automatic t_regs;
		rd(A_TA_PERIOD);
		chk(rv, 32'h0000FFFF);
		rd(A_T8B_CFG);
		chk(rv, 32'h0000FF00);
		wr(A_TA_CC0, 32'h00012345);
		rd(A_TA_CC0);
		chk(rv, 32'h00002345);
		rd(8'hFC);
		chk(rr, RESP_SLV);
		wr(8'hFC, 32'h0);
		chk(rr, RESP_SLV);
	endtask : t_regs
	task automatic t_pwm;
		wr(A_TA_PRESC, 32'h1);
		wr(A_TA_PERIOD, 32'h3);
		wr(A_TA_CC0, 32'h2);
		for (int i = 1; i < NCH; i++)
			wr(A_TA_CC0 + 8'(4 * i), 32'hFFFF);
		wr(A_T8A_CFG, 32'h00020300);
		wr(A_MASK, 32'h1000);
		wr(A_CTRL, 32'h9);
		// Let the start-up wrap pass before counting
		repeat (4) @(posedge aclk);
		sample(16);
		chk(c[0], 8);
		chk(c[1], 8);
		chk(c[2], 2);
		chk(c[4], 4);
		chk(irq, 1);
		wr(A_CTRL, 0);
		rd(A_STATUS);
		chk(rv, 32'h3003);
		rd(A_STATUS);
		chk(rv, 0);
		repeat (2) @(posedge aclk);
		chk(irq, 0);
		wr(A_CTRL, 32'hB);
		repeat (4) @(posedge aclk);
		sample(16);
		chk(c[0], 4);
		wr(A_CTRL, 32'h41);
		ta_cap_in <= 5'h02;
		sample(4);
		rd(A_TA_CC0 + 8'h4);
		chk(rv < 4, 1);
		rd(A_STATUS);
		chk(rv[2], 1);
	endtask : t_pwm
	task automatic t_radio;
		wr(A_RT_PERIOD, 32'h3);
		wr(A_RT_CMP0, 32'h2);
		wr(A_RT_CMP0 + 8'h4, 32'h1);
		wr(A_RT_OCMP0, 32'h1);
		wr(A_RT_OCMP0 + 8'h4, 32'h2);
		wr(A_CTRL, 32'hC04);
		sample(40);
		chk(c[5], 1);
		chk(c[6], 1);
		chk(c[3], 10);
		fire_sfd <= 1;
		@(posedge aclk);
		fire_sfd <= 0;
		// Capture lands one edge after the radio pulse
		@(posedge aclk);
		rd(A_RT_CAPHI);
		chk(rv, 32'hA);
		rd(A_STATUS);
		chk(rv[7:6], 2'h3);
		wr(A_CTRL, 0);
		fire_end <= 1;
		@(posedge aclk);
		fire_end <= 0;
		@(posedge aclk);
		rd(A_RT_CAPHI);
		chk(rv, 0);
	endtask : t_radio
	// Reset, then the scenarios
	initial
	begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, fire_sfd, fire_end} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ta_cap_in} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		t_regs();
		t_pwm();
		t_radio();
		summarize();
	end
endmodule : tb_top
